// ### rtl/vdpm_ctrl.sv
/*
 * Voltage-code decode and phase-mode control of a two-phase buck controller.
 * Assumes volt_code and sleep_indicator_n are synchronous to ref_clk, and that
 * the analog side reports ramp completion, per-phase current sense, idle-phase
 * zero current and reverse inductor current as synchronous levels.
 */
`timescale 1ns/10ps
`default_nettype none
`include "vdpm_defs.svh"
module vdpm_ctrl (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic regulator_enable,
  input wire logic [5:0] volt_code,
  input wire logic sleep_indicator_n,
  input wire logic ramp_done,
  input wire logic [9:0] phase_current_sense1,
  input wire logic [9:0] phase_current_sense2,
  input wire logic idle_phase_zero,
  input wire logic reverse_current,
  output logic [10:0] target_mv_r,
  output logic phase1_pulse_r,
  output logic phase2_pulse_r,
  output logic phase2_enable_r,
  output logic diode_emul_r,
  output logic low_side_off_r,
  output logic shed_current_r,
  output logic active_phases_r,
  output logic [7:0] trim1_r,
  output logic [7:0] trim2_r
);
  vdpm_pkg::vdpm_mode_t mode_r;
  vdpm_pkg::vdpm_mode_t mode_nxt;
  logic [9:0] per_cnt_r;
  logic [7:0] start_cnt_r;
  logic [5:0] code_prev_r;
  logic code_chg;
  logic ramp_hold_r;
  vdpm_filt_if fif ();

  // ****************************
  // code decode
  // ****************************
  function automatic logic [10:0] vdpm_decode(input logic [5:0] c);
    logic [10:0] lo5;
    lo5 = {6'd0, c[4:0]};
    if (!c[5])
      vdpm_decode = `VDPM_MV_TOP_HI - 11'(lo5 * `VDPM_STEP_HI);
    else
      vdpm_decode = `VDPM_MV_TOP_LO - 11'((lo5 * `VDPM_HALF_LO) >> 1);
  endfunction : vdpm_decode

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      target_mv_r <= `VDPM_MV_TOP_HI;
    end else begin
      target_mv_r <= vdpm_decode(volt_code);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_prev_r <= 6'h00;
    end else begin
      code_prev_r <= volt_code;
    end
  end
  assign code_chg = code_prev_r != volt_code;

  // ramp in progress from a code change until ramp_done
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ramp_hold_r <= 1'b0;
    end else if (code_chg) begin
      ramp_hold_r <= 1'b1;
    end else if (ramp_done) begin
      ramp_hold_r <= 1'b0;
    end
  end

  // ****************************
  // switching period time base
  // ****************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      per_cnt_r <= 10'd0;
    end else if (per_cnt_r == `VDPM_PERIOD_CYC - 10'd1) begin
      per_cnt_r <= 10'd0;
    end else begin
      per_cnt_r <= per_cnt_r + 10'd1;
    end
  end

  // phase 1 at count 0, phase 2 half a period later
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase1_pulse_r <= 1'b0;
      phase2_pulse_r <= 1'b0;
    end else begin
      phase1_pulse_r <= regulator_enable && per_cnt_r == 10'd0;
      phase2_pulse_r <= regulator_enable && phase2_enable_r && per_cnt_r == `VDPM_HALF_CYC;
    end
  end

  assign fif.period_tick = per_cnt_r == 10'd0;
  assign fif.want_single = !sleep_indicator_n && mode_r != vdpm_pkg::VDPM_START;

  vdpm_glitch_filt u_filt (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .f(fif.filt)
  );

  // ****************************
  // start-up interval
  // ****************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_cnt_r <= 8'd0;
    end else if (!regulator_enable) begin
      start_cnt_r <= 8'd0;
    end else if (fif.period_tick && start_cnt_r != `VDPM_STARTUP_PERIODS) begin
      start_cnt_r <= start_cnt_r + 8'd1;
    end
  end

  // ****************************
  // mode machine
  // ****************************
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      vdpm_pkg::VDPM_START: begin
        if (start_cnt_r == `VDPM_STARTUP_PERIODS)
          mode_nxt = vdpm_pkg::VDPM_TWO;
      end
      vdpm_pkg::VDPM_TWO: begin
        // a ramp in flight delays shedding
        if (fif.idle_ok && !ramp_hold_r && !code_chg)
          mode_nxt = vdpm_pkg::VDPM_SHED;
      end
      vdpm_pkg::VDPM_SHED: begin
        if (sleep_indicator_n || code_chg)
          mode_nxt = vdpm_pkg::VDPM_TWO;
        else if (idle_phase_zero)
          mode_nxt = vdpm_pkg::VDPM_ONE;
      end
      vdpm_pkg::VDPM_ONE: begin
        if (sleep_indicator_n || code_chg)
          mode_nxt = vdpm_pkg::VDPM_TWO;
        else if (fif.de_ok)
          mode_nxt = vdpm_pkg::VDPM_DE;
      end
      vdpm_pkg::VDPM_DE: begin
        if (sleep_indicator_n || code_chg)
          mode_nxt = vdpm_pkg::VDPM_TWO;
      end
      default: mode_nxt = vdpm_pkg::VDPM_START;
    endcase
    if (!regulator_enable)
      mode_nxt = vdpm_pkg::VDPM_START;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_r <= vdpm_pkg::VDPM_START;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // outputs registered from the next mode so they align with mode_r
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase2_enable_r <= 1'b1;
      active_phases_r <= 1'b1;
      diode_emul_r <= 1'b0;
      shed_current_r <= 1'b0;
    end else begin
      phase2_enable_r <= mode_nxt inside {vdpm_pkg::VDPM_START, vdpm_pkg::VDPM_TWO, vdpm_pkg::VDPM_SHED};
      active_phases_r <= mode_nxt inside {vdpm_pkg::VDPM_START, vdpm_pkg::VDPM_TWO, vdpm_pkg::VDPM_SHED};
      diode_emul_r <= mode_nxt == vdpm_pkg::VDPM_DE;
      shed_current_r <= mode_nxt == vdpm_pkg::VDPM_SHED;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_side_off_r <= 1'b0;
    end else begin
      low_side_off_r <= mode_r == vdpm_pkg::VDPM_DE && reverse_current;
    end
  end

  // ****************************
  // current balancing
  // ****************************
  // one trim step per period; trim2 mirrors trim1 so the sum stays constant, except at trim1 8'h00 where trim2 wraps to 8'h00
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trim1_r <= `VDPM_TRIM_ZERO;
      trim2_r <= `VDPM_TRIM_ZERO;
    end else if (!phase2_enable_r) begin
      trim1_r <= `VDPM_TRIM_ZERO;
      trim2_r <= `VDPM_TRIM_ZERO;
    end else if (fif.period_tick) begin
      if (phase_current_sense1 > phase_current_sense2 && trim1_r != 8'h00) begin
        trim1_r <= trim1_r - 8'h01;
        trim2_r <= trim2_r + 8'h01;
      end else if (phase_current_sense1 < phase_current_sense2 && trim1_r != 8'hFF) begin
        trim1_r <= trim1_r + 8'h01;
        trim2_r <= trim2_r - 8'h01;
      end
    end
  end

  // ****************************
  // checks
  // ****************************
  sequence s_shed_zero;
    mode_r == vdpm_pkg::VDPM_SHED && idle_phase_zero && !sleep_indicator_n && !code_chg && regulator_enable;
  endsequence

  a_decode_val: assert property (@(posedge ref_clk) disable iff (sys_rst)
    1'b1 |=> target_mv_r == vdpm_decode($past(volt_code))) else $error("decode wrong");
  a_start_two: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mode_r == vdpm_pkg::VDPM_START |-> phase2_enable_r) else $error("startup not two-phase");
  a_ramp_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mode_r == vdpm_pkg::VDPM_TWO && ramp_hold_r |=> mode_r != vdpm_pkg::VDPM_SHED) else $error("shed during ramp");
  a_code_return: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mode_r == vdpm_pkg::VDPM_DE && code_chg && regulator_enable |=> mode_r == vdpm_pkg::VDPM_TWO && phase2_enable_r)
    else $error("no return on code change");
  a_shed_stop: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_shed_zero |=> !phase2_enable_r ##0 mode_r == vdpm_pkg::VDPM_ONE) else $error("idle phase not stopped");
  a_de_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(diode_emul_r) |-> fif.de_ok || $past(fif.de_ok)) else $error("early diode emulation");
  a_interleave: assert property (@(posedge ref_clk) disable iff (sys_rst)
    phase1_pulse_r && phase2_enable_r && regulator_enable && mode_r == vdpm_pkg::VDPM_TWO && !code_chg
    |-> ##166 (phase2_pulse_r || !phase2_enable_r)) else $error("phase offset wrong");
  a_reverse_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mode_r == vdpm_pkg::VDPM_DE && reverse_current |=> low_side_off_r) else $error("low side not off");
endmodule : vdpm_ctrl
`default_nettype wire

// ### rtl/vdpm_defs.svh
/*
 * Constants of the voltage-code decode and phase-mode control block.
 * Assumes the includer runs on a 100 MHz ref_clk.
 */
`ifndef VDPM_DEFS_SVH
`define VDPM_DEFS_SVH

`define VDPM_CODE_W 6
`define VDPM_MV_W 11
`define VDPM_MV_TOP_HI 11'd1550
`define VDPM_MV_TOP_LO 11'd762
`define VDPM_STEP_HI 11'd25
`define VDPM_HALF_LO 11'd25
`define VDPM_PER_W 10
`define VDPM_PERIOD_CYC 10'd333
`define VDPM_HALF_CYC 10'd166
`define VDPM_IDLE_PERIODS 3'd2
`define VDPM_DE_PERIODS 3'd7
`define VDPM_STARTUP_PERIODS 8'd64
`define VDPM_TRIM_W 8
`define VDPM_TRIM_ZERO 8'h80
`define VDPM_SENSE_W 10

`endif

// ### rtl/vdpm_pkg.sv
/*
 * Types of the phase-mode control block.
 * Assumes vdpm_defs.svh is included alongside.
 */
`default_nettype none
package vdpm_pkg;
  typedef enum logic [2:0] {
    VDPM_START = 3'b000,
    VDPM_TWO = 3'b001,
    VDPM_SHED = 3'b010,
    VDPM_ONE = 3'b011,
    VDPM_DE = 3'b100
  } vdpm_mode_t;
endpackage : vdpm_pkg
`default_nettype wire

// ### rtl/vdpm_filt_if.sv
/*
 * Carrier between mode control and the glitch filter.
 * Assumes one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
interface vdpm_filt_if;
  logic period_tick;
  logic want_single;
  logic idle_ok;
  logic de_ok;
  modport ctrl (output period_tick, output want_single, input idle_ok, input de_ok);
  modport filt (input period_tick, input want_single, output idle_ok, output de_ok);
endinterface : vdpm_filt_if
`default_nettype wire

// ### rtl/vdpm_glitch_filt.sv
/*
 * Glitch filter counting switching periods of a persistent single-phase request.
 * Assumes period_tick is one-cycle per switching period.
 */
`timescale 1ns/10ps
`default_nettype none
`include "vdpm_defs.svh"
module vdpm_glitch_filt (
  input wire logic ref_clk,
  input wire logic sys_rst,
  vdpm_filt_if.filt f
);
  logic [3:0] cnt_r;

  // ****************************
  // period counter
  // ****************************
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r <= 4'h0;
    end else if (!f.want_single) begin
      cnt_r <= 4'h0;
    end else if (f.period_tick && cnt_r != ({1'b0, `VDPM_DE_PERIODS} + 4'h1)) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // first tick lands at any phase of the period, so one tick beyond the
  // threshold is needed before whole periods are guaranteed
  assign f.idle_ok = cnt_r > {1'b0, `VDPM_IDLE_PERIODS};
  assign f.de_ok = cnt_r > {1'b0, `VDPM_DE_PERIODS};

  a_filt_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !f.want_single |=> cnt_r == 4'h0) else $error("filter did not clear");
endmodule : vdpm_glitch_filt
`default_nettype wire

// ### verification/vdpm_cpu_model.sv
/*
 * Processor-side model: drives the voltage code and the sleep indicator.
 * Assumes callers sit just after a ref_clk rising edge.
 */
`timescale 1ns/10ps
`default_nettype none
module vdpm_cpu_model (
  input wire logic ref_clk,
  output logic [5:0] volt_code,
  output logic sleep_indicator_n
);
  initial begin
    volt_code = 6'h00;
    sleep_indicator_n = 1'b1;
  end

  // whole code and sleep level change together, just after an edge
  task automatic send(input logic [5:0] code, input logic sleep_n);
    @(posedge ref_clk);
    #1;
    volt_code = code;
    sleep_indicator_n = sleep_n;
  endtask : send
endmodule : vdpm_cpu_model
`default_nettype wire

// ### verification/test_vid_decode_phase_mode_ctrl.sv
/*
 * Self-checking bench of the voltage-code decode and phase-mode control.
 * Assumes vdpm_ctrl and vdpm_cpu_model are compiled alongside.
 */
`timescale 1ns/10ps
`default_nettype none
module test_vid_decode_phase_mode_ctrl;
  logic ref_clk, sys_rst, regulator_enable, ramp_done, idle_phase_zero, reverse_current;
  logic [9:0] sense1, sense2;
  logic [5:0] volt_code;
  logic sleep_indicator_n;
  logic [10:0] target_mv_r;
  logic phase1_pulse_r, phase2_pulse_r, phase2_enable_r, diode_emul_r;
  logic low_side_off_r, shed_current_r, active_phases_r;
  logic [7:0] trim1_r, trim2_r;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;

  vdpm_cpu_model i_vdpm_cpu_model (.ref_clk(ref_clk), .volt_code(volt_code),
    .sleep_indicator_n(sleep_indicator_n));
  vdpm_ctrl i_vdpm_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .regulator_enable(regulator_enable),
    .volt_code(volt_code), .sleep_indicator_n(sleep_indicator_n), .ramp_done(ramp_done),
    .phase_current_sense1(sense1), .phase_current_sense2(sense2), .idle_phase_zero(idle_phase_zero),
    .reverse_current(reverse_current), .target_mv_r(target_mv_r), .phase1_pulse_r(phase1_pulse_r),
    .phase2_pulse_r(phase2_pulse_r), .phase2_enable_r(phase2_enable_r), .diode_emul_r(diode_emul_r),
    .low_side_off_r(low_side_off_r), .shed_current_r(shed_current_r),
    .active_phases_r(active_phases_r), .trim1_r(trim1_r), .trim2_r(trim2_r));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ********************
  // helpers
  // ********************
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic chk_val(input string what, input logic [10:0] exp, input logic [10:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // generous ceiling; the sequence needs about 33k cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 80000) begin
      fails++;
      conclude();
    end
  end

  // ********************
  // scenarios
  // ********************
  task automatic t_decode;
    int c;
    for (c = 0; c < 64; c++) begin
      i_vdpm_cpu_model.send(c[5:0], 1'b0);
      step(1);
      chk_val("target", (c < 32) ? 11'(1550 - 25 * c) : 11'((1525 - 25 * (c - 32)) / 2), target_mv_r);
    end
    step(62 * 333);
    chk_bit("start_two", 1'b1, active_phases_r);
    i_vdpm_cpu_model.send(6'h10, 1'b1);
    step(3 * 333);
  endtask : t_decode

  task automatic t_interleave;
    int n;
    for (n = 0; n < 400 && phase1_pulse_r !== 1'b1; n++) step(1);
    for (n = 0; n < 400 && phase2_pulse_r !== 1'b1; n++) step(1);
    chk_val("p2_offset", 11'd166, 11'(n));
    for (n = 0; n < 400 && phase1_pulse_r !== 1'b1; n++) step(1);
    chk_val("p1_return", 11'd167, 11'(n));
  endtask : t_interleave

  task automatic t_glitch;
    logic seen;
    seen = 1'b0;
    // two lows just under two periods: a counter that never clears, or one
    // that sheds on two bare ticks, would shed here
    repeat (2) begin
      i_vdpm_cpu_model.send(volt_code, 1'b0);
      repeat (600) begin step(1); seen |= shed_current_r; end
      i_vdpm_cpu_model.send(volt_code, 1'b1);
      repeat (100) begin step(1); seen |= shed_current_r; end
    end
    chk_bit("glitch_shed", 1'b0, seen);
  endtask : t_glitch

  task automatic t_balance;
    sense1 = 10'h258;
    sense2 = 10'h190;
    step(10 * 333);
    chk_bit("trim_dir", 1'b1, trim1_r < trim2_r);
    sense1 = 10'h1F4;
    sense2 = 10'h1F4;
  endtask : t_balance

  task automatic t_single;
    int k;
    i_vdpm_cpu_model.send(volt_code, 1'b0);
    for (k = 0; k < 1400 && shed_current_r !== 1'b1; k++) step(1);
    chk_bit("shed", 1'b1, shed_current_r);
    chk_bit("shed_late", 1'b1, k >= 2 * 333);
    step(5);
    chk_bit("p2_held", 1'b1, phase2_enable_r);
    idle_phase_zero = 1'b1;
    step(3);
    chk_bit("one_phase", 1'b0, active_phases_r);
    for (k = k + 8; k < 2800 && diode_emul_r !== 1'b1; k++) step(1);
    chk_bit("de_late", 1'b1, k >= 7 * 333);
    chk_bit("de_on", 1'b1, diode_emul_r);
    reverse_current = 1'b1;
    step(2);
    chk_bit("low_off", 1'b1, low_side_off_r);
    reverse_current = 1'b0;
    i_vdpm_cpu_model.send(volt_code ^ 6'h01, 1'b0);
    step(1);
    chk_bit("de_left", 1'b0, diode_emul_r);
    chk_bit("p2_back", 1'b1, phase2_enable_r);
  endtask : t_single

  task automatic t_ramp_hold;
    int k;
    logic seen;
    idle_phase_zero = 1'b0;
    i_vdpm_cpu_model.send(volt_code, 1'b1);
    step(10);
    ramp_done = 1'b0;
    i_vdpm_cpu_model.send(volt_code ^ 6'h02, 1'b0);
    seen = 1'b0;
    repeat (1000) begin step(1); seen |= shed_current_r; end
    chk_bit("shed_in_ramp", 1'b0, seen);
    ramp_done = 1'b1;
    for (k = 0; k < 1000 && shed_current_r !== 1'b1; k++) step(1);
    chk_bit("shed_after_ramp", 1'b1, shed_current_r);
  endtask : t_ramp_hold

  // enable drop restarts; sleep stays low through the new start-up
  task automatic t_restart;
    step(400);
    regulator_enable = 1'b0;
    step(2);
    chk_bit("restart_two", 1'b1, phase2_enable_r);
    chk_bit("restart_shed", 1'b0, shed_current_r);
    regulator_enable = 1'b1;
    step(1400);
    chk_bit("startup_two", 1'b1, active_phases_r);
    chk_bit("startup_noshed", 1'b0, shed_current_r);
  endtask : t_restart

  initial begin
    sys_rst = 1'b1;
    regulator_enable = 1'b1;
    ramp_done = 1'b1;
    idle_phase_zero = 1'b0;
    reverse_current = 1'b0;
    sense1 = 10'h1F4;
    sense2 = 10'h1F4;
    repeat (5) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    t_decode();
    t_interleave();
    t_glitch();
    t_balance();
    t_single();
    t_ramp_hold();
    t_restart();
    conclude();
  end
endmodule : test_vid_decode_phase_mode_ctrl
`default_nettype wire
